// [rtl/ilt_tag_regs.sv]
// Operation
// - Tag region sits inside one 4 KB aligned page.
// - The page holds only tag registers; nothing else decodes there.
// - Writes to reserved fields or offsets change nothing.
// - Writes above the supported tag maximum are ignored.
// - Flag bit 3 set means 2-byte registers, clear means 8-byte; spacing matches.
// - Flag bit 1 monitor tagging, bit 2 class tagging; others reserved zero.
// - Descriptor offsets: monitor block at byte 10, class block at byte 12.
// - Block base is a 64-bit absolute physical address.
// - Class and monitor entries are contiguous arrays, entry n at offset plus n*width.
// - Each array holds exactly the channel count given at descriptor byte 7.
// - Class entry n selects the class for all traffic on channel n.
// - Link type 0x0 PCIe or CXL.io, 0x1 CXL.cache, 0x2 up reserved.
// - CXL.cache links implement only the channel 0 entries.
// - PCIe and CXL.io traffic on one link share the same entries.
// - Tags may be written and read any time and apply to later traffic; writes in a locked sequence (mmio_lock) are dropped, locked reads answer.
`timescale 1ns/100ps
module ilt_tag_regs #(
   parameter int CHAN_MAX = 8,
   parameter int TAG_W = 12,
   parameter logic [7:0] CHAN_COUNT = 8'h08,
   parameter logic [15:0] LINK_TYPE = 16'h0000,
   parameter logic REG_NARROW = 1'b0,
   parameter logic MON_SUPPORTED = 1'b1,
   parameter logic CLASS_SUPPORTED = 1'b1,
   parameter logic [15:0] MON_BLOCK_OFF = 16'h0100,
   parameter logic [15:0] CLASS_BLOCK_OFF = 16'h0040,
   parameter logic [63:0] BLOCK_BASE = 64'h0000_0000_FED0_0000
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic mmio_valid, // Access request, one cycle
   input wire logic mmio_write, // 1 write, 0 read
   input wire logic mmio_lock, // Request is part of a locked sequence
   input wire logic [ilt_pkg::ILT_PAGE_AW-1:0] mmio_addr, // Byte offset in page
   input wire logic [ilt_pkg::ILT_BUS_DW-1:0] mmio_wdata, // Write data
   output logic mmio_ack, // Answer pulse, two cycles after request
   output logic [ilt_pkg::ILT_BUS_DW-1:0] mmio_rdata, // Read data, zero for writes
   input wire logic [7:0] traffic_chan, // Channel of the traffic being tagged
   output logic [TAG_W-1:0] traffic_class_tag, // Class tag, one cycle later
   output logic [TAG_W-1:0] traffic_mon_tag, // Monitor tag, one cycle later
   output logic [15:0] desc_link_type, // Descriptor link type
   output logic [7:0] desc_chan_count, // Descriptor channel count
   output logic [15:0] desc_flags, // Descriptor flags
   output logic [15:0] desc_mon_off, // Descriptor monitor block offset
   output logic [15:0] desc_class_off, // Descriptor class block offset
   output logic [63:0] desc_block_base // Descriptor block base address
);
   import ilt_pkg::*;

   localparam int AW = (CHAN_MAX > 1) ? $clog2(CHAN_MAX) : 1;

   // Entry decode shared by both arrays: returns hit flag and entry index
   function automatic logic [16:0] entry_decode(
      input logic [ILT_PAGE_AW-1:0] addr,
      input logic [15:0] blk_off,
      input logic [3:0] shift,
      input logic [7:0] count
   );
      logic [15:0] rel;
      logic [15:0] idx;
      logic [15:0] amask;
      logic hit;
      rel = {4'h0, addr} - blk_off;
      idx = rel >> shift;
      amask = (16'h0001 << shift) - 16'h0001;
      hit = ({4'h0, addr} >= blk_off) && ((rel & amask) == 16'h0000)
            && (idx < {8'h00, count});
      entry_decode = {hit, idx};
   endfunction : entry_decode

   // Implemented channel count, bounded by the storage depth
   wire logic is_cxl = (LINK_TYPE == ILT_LINK_CXL_CACHE);
   wire logic [7:0] depth_cap = 8'(CHAN_MAX);
   wire logic [7:0] req_count = is_cxl ? 8'h01 : CHAN_COUNT;
   wire logic [7:0] chan_impl = (req_count > depth_cap) ? depth_cap : req_count;
   wire logic [3:0] idx_shift = REG_NARROW ? ILT_SHIFT_NARROW : ILT_SHIFT_WIDE;

   // Descriptor view of this block
   assign desc_link_type = (LINK_TYPE >= ILT_LINK_RESERVED_MIN) ? ILT_LINK_PCIE_IO
                           : LINK_TYPE;
   assign desc_chan_count = chan_impl;
   always_comb begin
      desc_flags = 16'h0000;
      desc_flags[ILT_FLAG_MON_TAG_POS] = MON_SUPPORTED;
      desc_flags[ILT_FLAG_CLASS_TAG_POS] = CLASS_SUPPORTED;
      desc_flags[ILT_FLAG_REG_WIDTH_SEL_POS] = REG_NARROW;
   end
   assign desc_mon_off = MON_BLOCK_OFF;
   assign desc_class_off = CLASS_BLOCK_OFF;
   // Base forced onto a page boundary, absolute address, no BAR relation
   assign desc_block_base = {BLOCK_BASE[63:ILT_PAGE_AW], {ILT_PAGE_AW{1'b0}}};

   // Bus decode
   wire logic [16:0] cls_dec = entry_decode(mmio_addr, CLASS_BLOCK_OFF, idx_shift, chan_impl);
   wire logic [16:0] mon_dec = entry_decode(mmio_addr, MON_BLOCK_OFF, idx_shift, chan_impl);
   wire logic cls_hit = cls_dec[16] && CLASS_SUPPORTED;
   wire logic mon_hit = mon_dec[16] && MON_SUPPORTED;
   wire logic [AW-1:0] cls_idx = cls_dec[AW-1:0];
   wire logic [AW-1:0] mon_idx = mon_dec[AW-1:0];

   // Upper bits of the register width are reserved, as are bits above the tag width
   wire logic [63:0] width_mask = REG_NARROW ? 64'h0000_0000_0000_FFFF : 64'hFFFF_FFFF_FFFF_FFFF;
   wire logic [63:0] tag_mask = {{(64-TAG_W){1'b0}}, {TAG_W{1'b1}}};
   wire logic value_ok = ((mmio_wdata & width_mask & ~tag_mask) == 64'h0);
   // Locked writes are not supported; dropping them keeps the state coherent, locked reads still answer
   wire logic wr_ok = mmio_valid && mmio_write && !mmio_lock && value_ok;
   wire logic cls_wr = wr_ok && cls_hit;
   wire logic mon_wr = wr_ok && mon_hit;
   wire logic rd_req = mmio_valid && !mmio_write;
   wire logic [TAG_W-1:0] wr_tag = mmio_wdata[TAG_W-1:0];

   // Traffic lookup: one entry per channel for every protocol on the link
   wire logic traffic_in = (traffic_chan < chan_impl);
   wire logic [AW-1:0] traffic_idx = traffic_chan[AW-1:0];

   logic [TAG_W-1:0] cls_rd;
   logic [TAG_W-1:0] mon_rd;

   ilt_tag_mem #(
      .W(TAG_W),
      .DEPTH(CHAN_MAX),
      .AW(AW)
   ) u_class_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(cls_wr),
      .wr_idx(cls_idx),
      .wr_data(wr_tag),
      .a_en(rd_req && cls_hit),
      .a_idx(cls_idx),
      .a_data(cls_rd),
      .b_en(traffic_in && CLASS_SUPPORTED),
      .b_idx(traffic_idx),
      .b_data(traffic_class_tag)
   );

   ilt_tag_mem #(
      .W(TAG_W),
      .DEPTH(CHAN_MAX),
      .AW(AW)
   ) u_mon_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(mon_wr),
      .wr_idx(mon_idx),
      .wr_data(wr_tag),
      .a_en(rd_req && mon_hit),
      .a_idx(mon_idx),
      .a_data(mon_rd),
      .b_en(traffic_in && MON_SUPPORTED),
      .b_idx(traffic_idx),
      .b_data(traffic_mon_tag)
   );

   // Answer pipeline: memory read stage then the bus data register
   logic s1_valid_q;
   logic s1_rd_q;
   logic ack_q;
   logic [63:0] rdata_q;

   // Only one array can hit, so an OR merges them; misses read zero
   wire logic [63:0] rd_merge = {{(64-TAG_W){1'b0}}, cls_rd | mon_rd};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_valid_q <= 1'b0;
         s1_rd_q <= 1'b0;
      end else begin
         s1_valid_q <= mmio_valid;
         s1_rd_q <= rd_req;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         rdata_q <= 64'h0;
      end else begin
         ack_q <= s1_valid_q;
         rdata_q <= s1_rd_q ? rd_merge : 64'h0;
      end
   end

   assign mmio_ack = ack_q;
   assign mmio_rdata = rdata_q;
endmodule : ilt_tag_regs

// [shared/ilt_pkg.sv]
package ilt_pkg;
   // Register page
   localparam int ILT_PAGE_BYTES = 4096;
   localparam int ILT_PAGE_AW = 12;
   localparam int ILT_BUS_DW = 64;
   // Descriptor byte positions
   localparam int ILT_DESC_LINK_TYPE_POS = 4;
   localparam int ILT_DESC_CHAN_COUNT_POS = 7;
   localparam int ILT_DESC_FLAGS_POS = 8;
   localparam int ILT_DESC_MON_OFF_POS = 10;
   localparam int ILT_DESC_CLASS_OFF_POS = 12;
   localparam int ILT_DESC_BASE_POS = 32;
   // Descriptor flag bit positions
   localparam int ILT_FLAG_MON_TAG_POS = 1;
   localparam int ILT_FLAG_CLASS_TAG_POS = 2;
   localparam int ILT_FLAG_REG_WIDTH_SEL_POS = 3;
   // Register widths in bytes and the matching index shifts
   localparam int ILT_REG_BYTES_NARROW = 2;
   localparam int ILT_REG_BYTES_WIDE = 8;
   localparam logic [3:0] ILT_SHIFT_NARROW = 4'h1;
   localparam logic [3:0] ILT_SHIFT_WIDE = 4'h3;
   // Link interface type codes
   localparam logic [15:0] ILT_LINK_PCIE_IO = 16'h0000;
   localparam logic [15:0] ILT_LINK_CXL_CACHE = 16'h0001;
   localparam logic [15:0] ILT_LINK_RESERVED_MIN = 16'h0002;
   // Reset value of every tag entry
   localparam logic [63:0] ILT_TAG_RESET = 64'h0000_0000_0000_0000;
   // Read answer latency in clock cycles
   localparam int ILT_ACK_LATENCY = 2;
endpackage : ilt_pkg

// [rtl/ilt_tag_mem.sv]
`timescale 1ns/100ps
module ilt_tag_mem #(
   parameter int W = 12,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, clears all entries
   input wire logic wr_en, // Write strobe
   input wire logic [AW-1:0] wr_idx, // Write entry
   input wire logic [W-1:0] wr_data, // Write value
   input wire logic a_en, // Port A read enable, zero when low
   input wire logic [AW-1:0] a_idx, // Port A entry
   output logic [W-1:0] a_data, // Port A registered data
   input wire logic b_en, // Port B read enable, zero when low
   input wire logic [AW-1:0] b_idx, // Port B entry
   output logic [W-1:0] b_data // Port B registered data
);
   import ilt_pkg::*;

   logic [W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= ILT_TAG_RESET[W-1:0];
         end
      end else if (wr_en) begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   // Disabled reads return zero so callers can OR several memories
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         a_data <= '0;
         b_data <= '0;
      end else begin
         a_data <= a_en ? mem_q[a_idx] : '0;
         b_data <= b_en ? mem_q[b_idx] : '0;
      end
   end
endmodule : ilt_tag_mem

// [tb/ilt_tag_regs_sva.sv]
`timescale 1ns/100ps
module ilt_tag_regs_chk #(
   parameter int TAG_W = 12
) (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic mmio_valid, // Request
   input wire logic mmio_write, // Write
   input wire logic mmio_ack, // Answer
   input wire logic [63:0] mmio_rdata, // Read data
   input wire logic [7:0] traffic_chan, // Lookup channel
   input wire logic [TAG_W-1:0] traffic_class_tag, // Class tag
   input wire logic [TAG_W-1:0] traffic_mon_tag, // Monitor tag
   input wire logic [15:0] desc_link_type, // Link type
   input wire logic [7:0] desc_chan_count, // Channel count
   input wire logic [15:0] desc_flags, // Flags
   input wire logic [63:0] desc_block_base // Base
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ack; mmio_valid |-> ##2 mmio_ack; endproperty
   property p_noack; mmio_ack |-> $past(mmio_valid, 2); endproperty
   property p_wrz; mmio_valid && mmio_write |-> ##2 mmio_rdata == 64'h0; endproperty
   property p_idle; !mmio_ack |-> mmio_rdata == 64'h0; endproperty
   property p_flags; desc_flags[0] == 1'b0 && desc_flags[15:4] == 12'h000; endproperty
   property p_page; desc_block_base[11:0] == 12'h000; endproperty
   property p_type; desc_link_type < 16'h0002; endproperty
   property p_oob;
      traffic_chan >= desc_chan_count |=> traffic_class_tag == '0 && traffic_mon_tag == '0;
   endproperty
   property p_rst; $fell(sys_rst) |-> !mmio_ack && traffic_class_tag == '0; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   a_noack: assert property (p_noack) else $error("stray ack");
   a_wrz: assert property (p_wrz) else $error("write data nonzero");
   a_idle: assert property (p_idle) else $error("data without ack");
   a_flags: assert property (p_flags) else $error("reserved flag set");
   a_page: assert property (p_page) else $error("base not page aligned");
   a_type: assert property (p_type) else $error("reserved link type");
   a_oob: assert property (p_oob) else $error("tag for absent channel");
   a_rst: assert property (p_rst) else $error("state after reset");
   c_wr: cover property (mmio_valid && mmio_write);
   c_rd: cover property (mmio_ack && mmio_rdata != 64'h0);
   c_oob: cover property (traffic_chan >= desc_chan_count);
endmodule : ilt_tag_regs_chk
bind ilt_tag_regs ilt_tag_regs_chk #(.TAG_W(TAG_W)) chk_inst (.clk, .sys_rst,
   .mmio_valid, .mmio_write, .mmio_ack, .mmio_rdata, .traffic_chan, .traffic_class_tag,
   .traffic_mon_tag, .desc_link_type, .desc_chan_count, .desc_flags, .desc_block_base);

// [tb/ilt_tag_regs_tb.sv]
`timescale 1ns/100ps
module ilt_tag_regs_tb;
   import ilt_pkg::*;
   logic clk = 0, sys_rst = 1, mmio_valid = 0, mmio_write = 0, mmio_lock = 0, mmio_ack;
   logic [11:0] mmio_addr = 12'h000, traffic_class_tag, traffic_mon_tag;
   logic [63:0] mmio_wdata = 64'h0, mmio_rdata, rdv, desc_block_base;
   logic [7:0] traffic_chan = 8'h00, desc_chan_count;
   logic [15:0] desc_link_type, desc_flags, desc_mon_off, desc_class_off;
   int mismatches = 0, comparisons = 0;
   ilt_tag_regs ilt_tag_regs_inst (.clk, .sys_rst, .mmio_valid, .mmio_write, .mmio_lock,
      .mmio_addr, .mmio_wdata, .mmio_ack, .mmio_rdata, .traffic_chan, .traffic_class_tag,
      .traffic_mon_tag, .desc_link_type, .desc_chan_count, .desc_flags, .desc_mon_off,
      .desc_class_off, .desc_block_base);
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // One access; the answer is awaited for a bounded number of cycles
   task automatic acc(input logic w, input logic lk, input logic [11:0] a,
                      input logic [63:0] d);
      @(posedge clk);
      mmio_valid <= 1'b1;
      mmio_write <= w;
      mmio_lock <= lk;
      mmio_addr <= a;
      mmio_wdata <= d;
      @(posedge clk);
      mmio_valid <= 1'b0;
      mmio_lock <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         if (mmio_ack === 1'b1) begin
            rdv = mmio_rdata;
            // Request cycle counts as cycle 0, so the first look is cycle 2
            chk(64'(i + 2), 64'(ILT_ACK_LATENCY));
            return;
         end
      end
      mismatches++;
      end_of_test();
   endtask : acc
   task automatic look(input logic [7:0] ch, input logic [11:0] ec, input logic [11:0] em);
      @(posedge clk);
      traffic_chan <= ch;
      @(posedge clk);
      #1;
      chk(traffic_class_tag, ec);
      chk(traffic_mon_tag, em);
   endtask : look
   task automatic t_reset;
      acc(1'b0, 1'b0, 12'h040, 64'h0);
      chk(rdv, ILT_TAG_RESET);
      acc(1'b0, 1'b0, 12'h138, 64'h0);
      chk(rdv, ILT_TAG_RESET);
      chk(desc_flags, 16'h0006);
      chk(desc_chan_count, 8'h08);
      chk(desc_mon_off, 16'h0100);
      chk(desc_class_off, 16'h0040);
      chk(desc_block_base, 64'h0000_0000_FED0_0000);
      chk(desc_link_type, ILT_LINK_PCIE_IO);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_rw;
      for (int n = 0; n < 8; n++) begin
         acc(1'b1, 1'b0, 12'h040 + 12'(n * 8), 64'(n + 1));
         acc(1'b1, 1'b0, 12'h100 + 12'(n * 8), 64'h0F00 + 64'(n));
      end
      for (int n = 0; n < 8; n++) begin
         acc(1'b0, 1'b0, 12'h040 + 12'(n * 8), 64'h0);
         chk(rdv, 64'(n + 1));
         acc(1'b0, 1'b0, 12'h100 + 12'(n * 8), 64'h0);
         chk(rdv, 64'h0F00 + 64'(n));
         look(8'(n), 12'(n + 1), 12'hF00 + 12'(n));
      end
      $display("t_rw done");
   endtask : t_rw
   task automatic t_refuse;
      acc(1'b1, 1'b0, 12'h041, 64'h777);
      acc(1'b1, 1'b0, 12'h040, 64'h1000);
      acc(1'b1, 1'b1, 12'h040, 64'h555);
      acc(1'b1, 1'b0, 12'h000, 64'h333);
      acc(1'b0, 1'b0, 12'h040, 64'h0);
      chk(rdv, 64'h1);
      acc(1'b0, 1'b0, 12'h000, 64'h0);
      chk(rdv, 64'h0);
      acc(1'b0, 1'b0, 12'h041, 64'h0);
      chk(rdv, 64'h0);
      acc(1'b0, 1'b0, 12'h080, 64'h0);
      chk(rdv, 64'h0);
      look(8'h08, 12'h000, 12'h000);
      // Live retag must reach the very next lookup
      acc(1'b1, 1'b0, 12'h040, 64'hABC);
      look(8'h00, 12'hABC, 12'hF00);
      $display("t_refuse done");
   endtask : t_refuse
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_rw();
      t_refuse();
      end_of_test();
   end
endmodule : ilt_tag_regs_tb
